// [rtl/tributary_protocol_event_reporter.v]
// Tributary protocol event reporter: state changes and control responses
//
// What this block does
// - Start message in run posts code 010 naming the sender's address.
// - Start message in run halts protocol and returns all held buffers.
// - Maintenance message in run or start-up posts 12, returns, halts.
// - That maintenance case then enters maintenance and drops the message.
// - Maintenance message while halted posts 14, enters maintenance, drops it.
// - Start message in maintenance posts 16 and does nothing else.
// - Control station posts 22 when a tributary's polling goes dead.
// - Polling-dead report is ignored in point-to-point operation.
// - Response carries address byte, buffer address fields and code byte.
// - Halt on host halt command, start in run, or maintenance message in run or start-up.
`timescale 1ns/1ns
`include "trib_event_map.vh"
module tributary_protocol_event_reporter #(
  parameter ADDR_W = 5,
  parameter BUF_W = 22
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Station configuration
  input wire controlStation,
  input wire multipoint,
  // Received message events from the line receiver
  input wire startMsgValid,
  input wire maintMsgValid,
  input wire [ADDR_W-1:0] rxTribAddr,
  output reg rxReady,
  output reg msgDiscard,
  // Polling-dead event from the poller
  input wire pollDeadValid,
  input wire [ADDR_W-1:0] pollTribAddr,
  output reg pollReady,
  // Host commands
  input wire hostHaltValid,
  input wire hostStartupValid,
  input wire [ADDR_W-1:0] hostTribAddr,
  output reg hostReady,
  // Start-up sequencer state updates
  input wire seqAckValid,
  input wire seqRunValid,
  input wire [ADDR_W-1:0] seqTribAddr,
  output reg seqReady,
  // Buffer return request to the buffer manager
  output reg bufReturnValid,
  output reg [ADDR_W-1:0] bufReturnTrib,
  input wire bufReturnDone,
  input wire [BUF_W-1:0] bufReturnAddr,
  // Protocol halt strobe
  output reg protoHalt,
  output reg [ADDR_W-1:0] protoHaltTrib,
  // Control response to the host
  output reg respValid,
  output reg [7:0] tributary_address_byte,
  output reg [BUF_W-1:0] respBufAddr,
  output reg [7:0] response_code_byte,
  input wire respReady,
  // Current state of the addressed tributary
  output reg [2:0] tribState
);
  localparam S_IDLE = 3'h0;
  localparam S_READ = 3'h1;
  localparam S_DECIDE = 3'h2;
  localparam S_RETURN = 3'h3;
  localparam S_POST = 3'h4;

  reg [2:0] fsm_q;
  reg [1:0] evKind_q;
  reg [ADDR_W-1:0] evTrib_q;
  reg [7:0] evCode_q;
  reg [2:0] evNext_q;
  reg evRet_q;
  reg evPost_q;
  reg ramWe;
  reg [2:0] ramWd;
  reg [ADDR_W-1:0] ramWa;
  wire [2:0] curState;
  wire pollOk;

  // Running or either start-up state
  function active;
    input [2:0] s;
    begin
      active = (s == `ST_RUN) || (s == `ST_START_INIT) ||
        (s == `ST_START_ACK);
    end
  endfunction

  trib_state_ram #(
    .ADDR_W(ADDR_W)
  ) u_state (
    .ref_clk(ref_clk),
    .rst(rst),
    .rdAddr(evTrib_q),
    .rdData(curState),
    .wrEn(ramWe),
    .wrAddr(ramWa),
    .wrData(ramWd)
  );

  // Dead polling only means something at a multipoint control station
  assign pollOk = controlStation & multipoint;

  // Host and sequencer updates are written when the event slot is idle;
  // received events win the slot to keep line events from being lost.
  always @*
  begin
    ramWe = 1'b0;
    ramWa = evTrib_q;
    ramWd = evNext_q;
    if (fsm_q == S_POST && respValid && respReady)
      ramWe = (evNext_q != curState);
    else if (fsm_q == S_IDLE && !(startMsgValid || maintMsgValid) &&
      !pollDeadValid)
    begin
      if (hostHaltValid)
      begin
        ramWe = 1'b1;
        ramWa = hostTribAddr;
        ramWd = `ST_HALTED;
      end
      else if (hostStartupValid)
      begin
        ramWe = 1'b1;
        ramWa = hostTribAddr;
        ramWd = `ST_START_INIT;
      end
      else if (seqAckValid || seqRunValid)
      begin
        ramWe = 1'b1;
        ramWa = seqTribAddr;
        ramWd = seqRunValid ? `ST_RUN : `ST_START_ACK;
      end
    end
  end

  // Event sequencer: one event in flight, one response at a time
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      fsm_q <= S_IDLE;
      evKind_q <= `EV_START;
      evTrib_q <= {ADDR_W{1'b0}};
      evCode_q <= 8'h00;
      evNext_q <= `ST_RESET;
      evRet_q <= 1'b0;
      evPost_q <= 1'b0;
      rxReady <= 1'b0;
      msgDiscard <= 1'b0;
      pollReady <= 1'b0;
      hostReady <= 1'b0;
      seqReady <= 1'b0;
      bufReturnValid <= 1'b0;
      bufReturnTrib <= {ADDR_W{1'b0}};
      protoHalt <= 1'b0;
      protoHaltTrib <= {ADDR_W{1'b0}};
      respValid <= 1'b0;
      tributary_address_byte <= 8'h00;
      respBufAddr <= {BUF_W{1'b0}};
      response_code_byte <= 8'h00;
      tribState <= `ST_RESET;
    end
    else
    begin
      rxReady <= 1'b0;
      msgDiscard <= 1'b0;
      pollReady <= 1'b0;
      hostReady <= 1'b0;
      seqReady <= 1'b0;
      protoHalt <= 1'b0;
      case (fsm_q)
        S_IDLE:
        begin
          if (startMsgValid || maintMsgValid)
          begin
            evKind_q <= maintMsgValid ? `EV_MAINT : `EV_START;
            evTrib_q <= rxTribAddr;
            rxReady <= 1'b1;
            fsm_q <= S_READ;
          end
          else if (pollDeadValid)
          begin
            evKind_q <= `EV_POLL_DEAD;
            evTrib_q <= pollTribAddr;
            pollReady <= 1'b1;
            fsm_q <= pollOk ? S_READ : S_IDLE;
          end
          else if (hostHaltValid || hostStartupValid)
          begin
            hostReady <= 1'b1;
            protoHalt <= hostHaltValid;
            protoHaltTrib <= hostTribAddr;
            tribState <= ramWd;
          end
          else if (seqAckValid || seqRunValid)
          begin
            seqReady <= 1'b1;
            tribState <= ramWd;
          end
        end
        S_READ:
          fsm_q <= S_DECIDE; // RAM read latency
        S_DECIDE:
        begin
          tribState <= curState;
          evNext_q <= curState;
          evRet_q <= 1'b0;
          evPost_q <= 1'b0;
          fsm_q <= S_POST;
          case (evKind_q)
            `EV_START:
              if (curState == `ST_RUN)
              begin
                evCode_q <= `CODE_START_RUN;
                evNext_q <= `ST_HALTED;
                evRet_q <= 1'b1;
                evPost_q <= 1'b1;
              end
              else if (curState == `ST_MAINT)
              begin
                evCode_q <= `CODE_START_MAINT;
                evPost_q <= 1'b1;
              end
            `EV_MAINT:
              if (active(curState))
              begin
                evCode_q <= `CODE_MAINT_ACTIVE;
                evNext_q <= `ST_MAINT;
                evRet_q <= 1'b1;
                evPost_q <= 1'b1;
                msgDiscard <= 1'b1;
              end
              else if (curState == `ST_HALTED)
              begin
                evCode_q <= `CODE_MAINT_HALTED;
                evNext_q <= `ST_MAINT;
                evPost_q <= 1'b1;
                msgDiscard <= 1'b1;
              end
            `EV_POLL_DEAD:
            begin
              evCode_q <= `CODE_POLL_DEAD;
              evPost_q <= 1'b1;
            end
            default:
              fsm_q <= S_IDLE;
          endcase
        end
        S_POST:
        begin
          // Halt and buffer return precede the response
          if (evRet_q)
          begin
            protoHalt <= 1'b1;
            protoHaltTrib <= evTrib_q;
            bufReturnValid <= 1'b1;
            bufReturnTrib <= evTrib_q;
            evRet_q <= 1'b0;
            fsm_q <= S_RETURN;
          end
          else if (!evPost_q)
          begin
            fsm_q <= S_IDLE;
          end
          else if (!respValid)
          begin
            respValid <= 1'b1;
            tributary_address_byte <= {{(8-ADDR_W){1'b0}}, evTrib_q};
            response_code_byte <= evCode_q;
          end
          else if (respReady)
          begin
            respValid <= 1'b0;
            tribState <= evNext_q;
            fsm_q <= S_IDLE;
          end
        end
        S_RETURN:
          if (bufReturnDone)
          begin
            bufReturnValid <= 1'b0;
            respBufAddr <= bufReturnAddr;
            fsm_q <= S_POST;
          end
        default:
          fsm_q <= S_IDLE;
      endcase
    end
  end
endmodule // tributary_protocol_event_reporter

// [rtl/trib_event_map.vh]
// Event codes, state encodings and event kinds for the event reporter
`ifndef TRIB_EVENT_MAP_VH
`define TRIB_EVENT_MAP_VH
// Octal event codes posted in the response code byte
`define CODE_START_RUN 8'h08
`define CODE_MAINT_ACTIVE 8'h0A
`define CODE_MAINT_HALTED 8'h0C
`define CODE_START_MAINT 8'h0E
`define CODE_POLL_DEAD 8'h12
// Per-tributary protocol states
`define ST_HALTED 3'h0
`define ST_START_INIT 3'h1
`define ST_START_ACK 3'h2
`define ST_RUN 3'h3
`define ST_MAINT 3'h4
`define ST_RESET 3'h0
// Event kinds of the internal event slot
`define EV_START 2'h0
`define EV_MAINT 2'h1
`define EV_POLL_DEAD 2'h2
`endif

// [rtl/trib_state_ram.v]
// Per-tributary protocol state memory with registered read data
`timescale 1ns/1ns
`include "trib_event_map.vh"
module trib_state_ram #(
  parameter ADDR_W = 5
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Read port
  input wire [ADDR_W-1:0] rdAddr,
  output reg [2:0] rdData,
  // Write port
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [2:0] wrData
);
  localparam DEPTH = 1 << ADDR_W;
  reg [2:0] mem [0:DEPTH-1];
  reg [ADDR_W:0] clrIdx_q;
  wire clearing;

  // Reset sweeps every entry back to halted, one per cycle
  assign clearing = ~clrIdx_q[ADDR_W];

  // Sweep counter
  always @(posedge ref_clk)
  begin
    if (rst)
      clrIdx_q <= {(ADDR_W+1){1'b0}};
    else if (clearing)
      clrIdx_q <= clrIdx_q + {{ADDR_W{1'b0}}, 1'b1};
  end

  // Write port, sweep takes priority
  always @(posedge ref_clk)
  begin
    if (clearing)
      mem[clrIdx_q[ADDR_W-1:0]] <= `ST_RESET;
    else if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // Registered read; reads halted during the sweep
  always @(posedge ref_clk)
  begin
    if (rst || clearing)
      rdData <= `ST_RESET;
    else
      rdData <= mem[rdAddr];
  end
endmodule // trib_state_ram

// [tb/trib_event_checker.sv]
// Port-level assertions for the tributary event reporter
`timescale 1ns/1ns
`include "trib_event_map.vh"
module trib_event_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Watched ports
  input wire controlStation,
  input wire multipoint,
  input wire rxReady,
  input wire msgDiscard,
  input wire pollReady,
  input wire bufReturnValid,
  input wire bufReturnDone,
  input wire protoHalt,
  input wire respValid,
  input wire respReady,
  input wire [7:0] response_code_byte,
  input wire [7:0] tributary_address_byte,
  input wire [2:0] tribState
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Only the five event codes of this block may be posted
  code_set_a: assert property (respValid |-> response_code_byte inside
    {`CODE_START_RUN, `CODE_MAINT_ACTIVE, `CODE_MAINT_HALTED,
     `CODE_START_MAINT, `CODE_POLL_DEAD}) else $error("bad code");
  resp_hold_a: assert property (respValid && !respReady |=> respValid
    && $stable(response_code_byte) && $stable(tributary_address_byte))
    else $error("response dropped");
  halt_pulse_a: assert property (protoHalt |=> !protoHalt)
    else $error("halt not a pulse");
  ret_hold_a: assert property (bufReturnValid && !bufReturnDone
    |=> bufReturnValid) else $error("return dropped");
  ret_resp_a: assert property (bufReturnValid && bufReturnDone
    |-> ##[1:3] respValid) else $error("no response after return");
  halt_ret_a: assert property ($rose(bufReturnValid) |-> protoHalt)
    else $error("return without halt");
  maint_state_a: assert property (respValid && respReady
    && response_code_byte == `CODE_MAINT_ACTIVE |=> tribState == `ST_MAINT)
    else $error("not in maintenance");
  run_halt_a: assert property (respValid && respReady
    && response_code_byte == `CODE_START_RUN |=> tribState == `ST_HALTED)
    else $error("not halted");
  poll_quiet_a: assert property (pollReady && !(controlStation
    && multipoint) |=> !respValid [*6]) else $error("poll not ignored");
  rx_pulse_a: assert property (rxReady |=> !rxReady)
    else $error("ready not a pulse");
  discard_pulse_a: assert property (msgDiscard |=> !msgDiscard)
    else $error("discard not a pulse");
endmodule // trib_event_checker
bind tributary_protocol_event_reporter trib_event_checker chk (
  .ref_clk(ref_clk), .rst(rst), .controlStation(controlStation),
  .multipoint(multipoint), .rxReady(rxReady), .msgDiscard(msgDiscard),
  .pollReady(pollReady), .bufReturnValid(bufReturnValid),
  .bufReturnDone(bufReturnDone), .protoHalt(protoHalt),
  .respValid(respValid), .respReady(respReady),
  .response_code_byte(response_code_byte),
  .tributary_address_byte(tributary_address_byte), .tribState(tribState));

// [tb/buf_return_model.sv]
// Buffer manager model answering buffer return requests
`timescale 1ns/1ns
module buf_return_model (
  // Clock
  input wire ref_clk,
  // Return handshake
  input wire bufReturnValid,
  output reg bufReturnDone,
  output reg [21:0] bufReturnAddr,
  output reg [21:0] lastAddr
);
  integer seed = 911;
  reg [31:0] rnd;
  // Random stall; address toggles only between returns, holding through stall and done, so stale reads show
  initial
  begin
    bufReturnDone = 1'b0;
    bufReturnAddr = 22'h155555;
    lastAddr = 22'h000000;
    forever
    begin
      @(negedge ref_clk);
      bufReturnAddr = ~bufReturnAddr;
      if (bufReturnValid)
      begin
        repeat ($unsigned($random(seed)) % 6) @(negedge ref_clk);
        rnd = $random(seed);
        lastAddr = rnd[21:0];
        bufReturnAddr = lastAddr;
        bufReturnDone = 1'b1;
        @(negedge ref_clk);
        bufReturnDone = 1'b0;
        @(negedge ref_clk);
      end
    end
  end
endmodule // buf_return_model

// [tb/tb.sv]
// Self-checking bench for the tributary event reporter
`timescale 1ns/1ns
`include "trib_event_map.vh"
module tb;
  reg ref_clk, rst, cs, mp, sv, mv, pv, hh, hs, sa, sr, respReady;
  reg rdy, hx;
  reg [4:0] haltTrib, retTrib;
  reg [2:0] ts;
  reg [31:0] rnd;
  reg [59:0] walk;
  integer disCnt = 0;
  integer haltCnt = 0;
  integer dis0, halt0;
  reg [4:0] ad, ra;
  reg [2:0] kd;
  reg [2:0] st [0:31];
  reg [7:0] ec;
  integer seed = 2623;
  integer failures = 0;
  integer cmp_count = 0;
  integer i, n;
  wire rxReady, msgDiscard, pollReady, hostReady, seqReady, protoHalt;
  wire bufReturnValid, bufReturnDone, respValid;
  wire [4:0] bufReturnTrib, protoHaltTrib;
  wire [21:0] bufReturnAddr, respBufAddr, lastAddr;
  wire [7:0] tributary_address_byte, response_code_byte;
  wire [2:0] tribState;
  tributary_protocol_event_reporter dut (.ref_clk(ref_clk), .rst(rst),
    .controlStation(cs), .multipoint(mp), .startMsgValid(sv),
    .maintMsgValid(mv), .rxTribAddr(ad), .rxReady(rxReady),
    .msgDiscard(msgDiscard), .pollDeadValid(pv), .pollTribAddr(ad),
    .pollReady(pollReady), .hostHaltValid(hh), .hostStartupValid(hs),
    .hostTribAddr(ad), .hostReady(hostReady), .seqAckValid(sa),
    .seqRunValid(sr), .seqTribAddr(ad), .seqReady(seqReady),
    .bufReturnValid(bufReturnValid), .bufReturnTrib(bufReturnTrib),
    .bufReturnDone(bufReturnDone), .bufReturnAddr(bufReturnAddr),
    .protoHalt(protoHalt), .protoHaltTrib(protoHaltTrib),
    .respValid(respValid), .tributary_address_byte(tributary_address_byte),
    .respBufAddr(respBufAddr), .response_code_byte(response_code_byte),
    .respReady(respReady), .tribState(tribState));
  buf_return_model bm (.ref_clk(ref_clk), .bufReturnValid(bufReturnValid),
    .bufReturnDone(bufReturnDone), .bufReturnAddr(bufReturnAddr),
    .lastAddr(lastAddr));
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Side effects counted here only, so the task never drives them
  always @(posedge ref_clk)
  begin
    if (msgDiscard)
      disCnt <= disCnt + 1;
    if (protoHalt)
    begin
      haltCnt <= haltCnt + 1;
      haltTrib <= protoHaltTrib;
    end
    if (bufReturnValid)
      retTrib <= bufReturnTrib;
  end
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("mismatch %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // Expected code: 0 start, 1 maint, 2 poll, 3 halt, 4 startup, 5 ack, 6 run
  function [7:0] ecode(input [2:0] k, input [2:0] s, input c);
    begin
      ecode = 8'hFF;
      if (k == 3'h0 && s == `ST_RUN) ecode = `CODE_START_RUN;
      if (k == 3'h0 && s == `ST_MAINT) ecode = `CODE_START_MAINT;
      if (k == 3'h1 && s != `ST_MAINT) ecode = `CODE_MAINT_ACTIVE;
      if (k == 3'h1 && s == `ST_HALTED) ecode = `CODE_MAINT_HALTED;
      if (k == 3'h2 && c) ecode = `CODE_POLL_DEAD;
    end
  endfunction
  function [2:0] nstate(input [2:0] k, input [2:0] s);
    begin
      nstate = s;
      if (k == 3'h0 && s == `ST_RUN) nstate = `ST_HALTED;
      if (k == 3'h1) nstate = `ST_MAINT;
      if (k == 3'h3) nstate = `ST_HALTED;
      if (k >= 3'h4) nstate = k - 3'h3;
    end
  endfunction
  // One event: request held until its ready, then response and state
  task ev(input [2:0] k, input [4:0] a);
    begin
      ad = a;
      dis0 = disCnt;
      halt0 = haltCnt;
      ec = ecode(k, st[a], cs & mp);
      {sv, mv, pv, hh, hs, sa, sr} = 7'h40 >> k;
      n = 0;
      rdy = 1'b0;
      while (!rdy && n < 50)
      begin
        @(negedge ref_clk);
        n = n + 1;
        rdy = k < 2 ? rxReady : k == 2 ? pollReady : k < 5 ? hostReady
          : seqReady;
      end
      {sv, mv, pv, hh, hs, sa, sr} = 7'h00;
      check("ready", rdy, 1'b1);
      n = 0;
      while (ec != 8'hFF && respValid !== 1'b1 && n < 60)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (ec != 8'hFF)
      begin
        check("code", response_code_byte, ec);
        check("trib", tributary_address_byte, {3'h0, a});
        if (ec == 8'h08 || ec == 8'h0A)
        begin
          check("bufAddr", respBufAddr, lastAddr);
          check("retTrib", retTrib, a);
        end
        repeat ($unsigned($random(seed)) % 3) @(negedge ref_clk);
        respReady = 1'b1;
        @(negedge ref_clk);
        respReady = 1'b0;
      end
      else
        repeat (10) @(negedge ref_clk);
      check("idle", respValid, 1'b0);
      @(negedge ref_clk);
      st[a] = nstate(k, st[a]);
      // An ignored poll-dead report leaves the last shown state alone
      if (k != 3'h2 || (cs & mp))
        ts = st[a];
      check("state", tribState, ts);
      check("discard", disCnt - dis0, ec == 8'h0A || ec == 8'h0C);
      hx = k == 3'h3 || ec == 8'h08 || ec == 8'h0A;
      check("halt", haltCnt - halt0, hx);
      if (hx)
        check("haltTrib", haltTrib, a);
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Watchdog sized well above the expected event traffic
  initial
  begin
    #1000000;
    failures = failures + 1;
    end_of_test;
  end
  // Main sequence: directed walk through all states, then random events
  initial
  begin
    {rst, cs, mp, sv, mv, pv, hh, hs, sa, sr, respReady} = 11'h400;
    ad = 5'h00;
    ts = `ST_RESET;
    for (i = 0; i < 32; i = i + 1)
      st[i] = `ST_HALTED;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (40) @(negedge ref_clk);
    {cs, mp} = 2'b11;
    walk = 60'h456010134134510;
    for (i = 0; i < 15; i = i + 1)
    begin
      ev(walk[58:56], 5'h1F);
      walk = walk << 4;
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      rnd = i;
      {cs, mp} = rnd[1:0];
      ev(3'h2, rnd[4:0]);
    end
    for (i = 0; i < 300; i = i + 1)
    begin
      rnd = $random(seed);
      {cs, mp} = rnd[1:0];
      rnd = $random(seed);
      ra = rnd[4:0];
      rnd = $unsigned($random(seed)) % 7;
      kd = rnd[2:0];
      if (kd > 3 && st[ra] != kd - 3'h4)
        kd = 3'h1;
      ev(kd, ra);
    end
    end_of_test;
  end
endmodule // tb
